// ---- logic/asrc_pkg.sv ----
package asrc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ASRC_OFS_CTRL2 = 8'h00;
  localparam logic [7:0] ASRC_OFS_STATUS = 8'h04;
  localparam logic [7:0] ASRC_OFS_MASK = 8'h08;
  localparam logic [7:0] ASRC_OFS_STATE = 8'h0C;

  // ----------------------------------------------------------------
  // Conversion control 2 field layout
  // ----------------------------------------------------------------
  localparam int ASRC_REF_LSB = 13;
  localparam int ASRC_REF_MSB = 15;
  localparam int ASRC_CAL_BIT = 12;
  localparam int ASRC_SCAN_BIT = 10;
  localparam int ASRC_SPI_LSB = 2;
  localparam int ASRC_SPI_MSB = 5;
  localparam int ASRC_ALT_BIT = 0;
  // Only these bits hold state; the rest read as zero
  localparam logic [15:0] ASRC_CTRL2_WMASK = 16'hF43D;
  localparam logic [15:0] ASRC_CTRL2_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Status and mask layout
  // ----------------------------------------------------------------
  localparam int ASRC_EV_W = 2;
  localparam int ASRC_EV_IRQ = 0;
  localparam int ASRC_EV_SEQ = 1;
  localparam logic [ASRC_EV_W-1:0] ASRC_EV_RST = 2'h0;
  localparam int ASRC_ST_CNT_LSB = 0;
  localparam int ASRC_ST_ALT_BIT = 4;

  // ----------------------------------------------------------------
  // Reference source codes (low bits of the reference field)
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ASRC_REF_INT = 3'b000,
    ASRC_REF_PEXT = 3'b001,
    ASRC_REF_NEXT = 3'b010,
    ASRC_REF_BOTH = 3'b011
  } asrc_ref_e;

endpackage

// ---- logic/asrc_cfg_if.sv ----
interface asrc_cfg_if;
  import asrc_pkg::*;

  // Fields of conversion control 2
  logic [2:0] reference_select;
  logic offset_calibrate;
  logic primary_scan_enable;
  logic [3:0] sequences_per_interrupt;
  logic alternate_sample_select;
  // Sequencer state fed back to the registers
  logic [3:0] seq_count;
  logic use_alternate;

  modport regs (
    output reference_select, offset_calibrate, primary_scan_enable,
    output sequences_per_interrupt, alternate_sample_select,
    input seq_count, use_alternate
  );
  modport seq (
    input sequences_per_interrupt, alternate_sample_select,
    output seq_count, use_alternate
  );
  modport route (
    input reference_select, offset_calibrate, primary_scan_enable,
    input use_alternate
  );
endinterface

// ---- logic/asrc_seq.sv ----
module asrc_seq
  import asrc_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Front-end events
  input wire logic seq_begin,
  input wire logic sample_done,
  input wire logic seq_done,
  // Configuration and state
  asrc_cfg_if.seq cfg,
  // Interrupt point reached
  output logic irq_point
);

  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic alt_q;
  logic alt_d;
  logic hit;

  // ----------------------------------------------------------------
  // Sequence counting and selector alternation
  // ----------------------------------------------------------------
  // Reserved code 1111 still wraps after sixteen, so nothing hangs
  assign hit = seq_done && (cnt_q == cfg.sequences_per_interrupt);
  assign irq_point = hit;
  assign cnt_d = seq_begin ? 4'h0 : hit ? 4'h0 :
                 seq_done ? cnt_q + 4'h1 : cnt_q;
  assign alt_d = seq_begin ? 1'b0 :
                 !cfg.alternate_sample_select ? 1'b0 :
                 sample_done ? !alt_q : alt_q;
  assign cfg.seq_count = cnt_q;
  assign cfg.use_alternate = alt_q;

  // State registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_q <= 4'h0;
      alt_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      alt_q <= alt_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Sequences seen since the last restart, counted apart from cnt_q so
  // that a slip in the real counter shows up as a disagreement
  logic [3:0] seen_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      seen_q <= 4'h0;
    end
    else if (seq_begin || irq_point)
    begin
      seen_q <= 4'h0;
    end
    else if (seq_done)
    begin
      seen_q <= seen_q + 4'h1;
    end
  end

  chk_irq_after_n: assert property (
    @(posedge hclk) disable iff (!hresetn)
    irq_point == (seq_done && seen_q == cfg.sequences_per_interrupt))
    else $error("interrupt point without N+1 sequences");
  chk_count_restart: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (irq_point || seq_begin) |=> cnt_q == 4'h0)
    else $error("sequence counter did not restart");
  chk_alt_toggles: assert property (
    @(posedge hclk) disable iff (!hresetn)
    cfg.alternate_sample_select && sample_done && !seq_begin
      |=> alt_q != $past(alt_q))
    else $error("selector did not alternate");
  chk_begin_primary: assert property (
    @(posedge hclk) disable iff (!hresetn)
    seq_begin |=> !alt_q)
    else $error("sequencing did not begin on primary");
  cov_alt_run: cover property (
    @(posedge hclk) disable iff (!hresetn)
    alt_q ##1 !alt_q ##[1:20] alt_q);

endmodule

// ---- logic/asrc_route.sv ----
module asrc_route
  import asrc_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Configuration
  asrc_cfg_if.route cfg,
  // Front-end controls
  output logic vref_pos_ext,
  output logic vref_neg_ext,
  output logic input_ground_tie,
  output logic input_switch_en,
  output logic scan_enable,
  output logic select_alternate
);

  // Positive reference external for codes 001 and 011 only
  function automatic logic ref_pos(input logic [2:0] code);
    ref_pos = !code[2] && (code == ASRC_REF_PEXT || code == ASRC_REF_BOTH);
  endfunction

  // Negative reference external for codes 010 and 011 only
  function automatic logic ref_neg(input logic [2:0] code);
    ref_neg = !code[2] && (code == ASRC_REF_NEXT || code == ASRC_REF_BOTH);
  endfunction

  logic cal;
  assign cal = cfg.offset_calibrate;

  // ----------------------------------------------------------------
  // Registered controls to the analog front end
  // ----------------------------------------------------------------
  // Calibration ignores the input switch and alternation; references and scan still follow their bits
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      vref_pos_ext <= 1'b0;
      vref_neg_ext <= 1'b0;
      input_ground_tie <= 1'b0;
      input_switch_en <= 1'b0;
      scan_enable <= 1'b0;
      select_alternate <= 1'b0;
    end
    else
    begin
      vref_pos_ext <= ref_pos(cfg.reference_select);
      vref_neg_ext <= ref_neg(cfg.reference_select);
      input_ground_tie <= cal;
      input_switch_en <= !cal;
      scan_enable <= cfg.primary_scan_enable;
      select_alternate <= cfg.use_alternate && !cal;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_ref_fallback: assert property (
    @(posedge hclk) disable iff (!hresetn)
    cfg.reference_select[2] |=> !vref_pos_ext && !vref_neg_ext)
    else $error("reference fallback not internal");
  chk_ref_both_ext: assert property (
    @(posedge hclk) disable iff (!hresetn)
    cfg.reference_select == ASRC_REF_BOTH |=> vref_pos_ext && vref_neg_ext)
    else $error("both external references not selected");
  chk_cal_grounded: assert property (
    @(posedge hclk) disable iff (!hresetn)
    cal |=> input_ground_tie && !input_switch_en && !select_alternate)
    else $error("calibration input not grounded");
  chk_real_input: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !cal |=> input_switch_en && !input_ground_tie)
    else $error("real input not connected");
  chk_scan_follow: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ##1 scan_enable == $past(cfg.primary_scan_enable))
    else $error("scan enable does not follow its bit");
  cov_cal_mode: cover property (
    @(posedge hclk) disable iff (!hresetn)
    !input_ground_tie ##1 input_ground_tie);

endmodule

// ---- logic/asrc_top.sv ----
module asrc_top
  import asrc_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Front-end sequencing events, same clock
  input wire logic seq_begin,
  input wire logic sample_done,
  input wire logic seq_done,
  // Front-end controls
  output logic vref_pos_ext,
  output logic vref_neg_ext,
  output logic input_ground_tie,
  output logic input_switch_en,
  output logic scan_enable,
  output logic select_alternate,
  // Interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // Bus pipeline state
  // ----------------------------------------------------------------
  logic wr_pend_q;
  logic rd_pend_q;
  logic rd_rdy_q;
  logic [7:0] addr_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_mux;
  logic accept;
  logic wr_en;
  logic rd_cap;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0] ctrl2_q;
  logic [15:0] ctrl2_d;
  logic [ASRC_EV_W-1:0] status_q;
  logic [ASRC_EV_W-1:0] status_d;
  logic [ASRC_EV_W-1:0] mask_q;
  logic [ASRC_EV_W-1:0] events;
  logic [ASRC_EV_W-1:0] clr;
  logic irq_point;
  logic wr_ctrl2;
  logic wr_status;
  logic wr_mask;

  asrc_cfg_if cfg_if ();

  // ----------------------------------------------------------------
  // Address phase decode
  // ----------------------------------------------------------------
  // hsize is not checked: only whole-word transfers are issued here
  assign accept = hsel && htrans[1] && hready;
  // A read takes one wait state so its data always comes from a flop
  // and a write in the preceding data phase is already visible
  assign hreadyout = !(rd_pend_q && !rd_rdy_q);
  assign rd_cap = rd_pend_q && !rd_rdy_q;
  assign wr_en = wr_pend_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // Pipeline registers; a new address is taken only when ready
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h00;
    end
    else if (hreadyout)
    begin
      wr_pend_q <= accept && hwrite;
      rd_pend_q <= accept && !hwrite;
      addr_q <= haddr[7:0];
    end
  end

  // Wait-state flag for reads
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_rdy_q <= 1'b0;
    end
    else
    begin
      rd_rdy_q <= rd_cap;
    end
  end

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  assign wr_ctrl2 = wr_en && addr_q == ASRC_OFS_CTRL2;
  assign wr_status = wr_en && addr_q == ASRC_OFS_STATUS;
  assign wr_mask = wr_en && addr_q == ASRC_OFS_MASK;
  // Unimplemented and reserved bits never store, bit 1 included
  assign ctrl2_d = wr_ctrl2 ? (hwdata[15:0] & ASRC_CTRL2_WMASK)
                            : ctrl2_q;

  // Control register, all writable fields clear at reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl2_q <= ASRC_CTRL2_RST;
    end
    else
    begin
      ctrl2_q <= ctrl2_d;
    end
  end

  // ----------------------------------------------------------------
  // Field fan-out to the sub-blocks
  // ----------------------------------------------------------------
  assign cfg_if.reference_select = ctrl2_q[ASRC_REF_MSB:ASRC_REF_LSB];
  assign cfg_if.offset_calibrate = ctrl2_q[ASRC_CAL_BIT];
  assign cfg_if.primary_scan_enable = ctrl2_q[ASRC_SCAN_BIT];
  assign cfg_if.sequences_per_interrupt = ctrl2_q[ASRC_SPI_MSB:ASRC_SPI_LSB];
  assign cfg_if.alternate_sample_select = ctrl2_q[ASRC_ALT_BIT];

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  assign events[ASRC_EV_IRQ] = irq_point;
  assign events[ASRC_EV_SEQ] = seq_done;
  assign clr = wr_status ? hwdata[ASRC_EV_W-1:0] : ASRC_EV_RST;
  // A new event beats a write-one-to-clear in the same cycle
  assign status_d = (status_q & ~clr) | events;
  assign irq = |(status_q & mask_q);

  // Sticky status and mask registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      status_q <= ASRC_EV_RST;
      mask_q <= ASRC_EV_RST;
    end
    else
    begin
      status_q <= status_d;
      mask_q <= wr_mask ? hwdata[ASRC_EV_W-1:0] : mask_q;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Reserved bit 7 and unused bits return zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (addr_q)
      ASRC_OFS_CTRL2: rd_mux[15:0] = ctrl2_q;
      ASRC_OFS_STATUS: rd_mux[ASRC_EV_W-1:0] = status_q;
      ASRC_OFS_MASK: rd_mux[ASRC_EV_W-1:0] = mask_q;
      ASRC_OFS_STATE:
      begin
        rd_mux[ASRC_ST_CNT_LSB+:4] = cfg_if.seq_count;
        rd_mux[ASRC_ST_ALT_BIT] = cfg_if.use_alternate;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data flop, loaded in the wait state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata_q <= 32'h0000_0000;
    end
    else if (rd_cap)
    begin
      hrdata_q <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  asrc_seq u_seq (
    .hclk(hclk),
    .hresetn(hresetn),
    .seq_begin(seq_begin),
    .sample_done(sample_done),
    .seq_done(seq_done),
    .cfg(cfg_if.seq),
    .irq_point(irq_point)
  );

  asrc_route u_route (
    .hclk(hclk),
    .hresetn(hresetn),
    .cfg(cfg_if.route),
    .vref_pos_ext(vref_pos_ext),
    .vref_neg_ext(vref_neg_ext),
    .input_ground_tie(input_ground_tie),
    .input_switch_en(input_switch_en),
    .scan_enable(scan_enable),
    .select_alternate(select_alternate)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_ctrl2_unused: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_rdy_q && addr_q == ASRC_OFS_CTRL2
      |-> (hrdata[15:0] & ~ASRC_CTRL2_WMASK) == 16'h0000
          && hrdata[31:16] == 16'h0000)
    else $error("unused control bits read nonzero");
  chk_ctrl2_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_ctrl2 |=> ctrl2_q == ($past(hwdata[15:0]) & ASRC_CTRL2_WMASK))
    else $error("control write not stored");
  chk_irq_sets: assert property (
    @(posedge hclk) disable iff (!hresetn)
    irq_point |=> status_q[ASRC_EV_IRQ])
    else $error("interrupt point lost");
  chk_read_wait: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_cap |-> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  cov_irq_raised: cover property (
    @(posedge hclk) disable iff (!hresetn)
    !irq ##1 irq);
  cov_status_clear: cover property (
    @(posedge hclk) disable iff (!hresetn)
    status_q[ASRC_EV_IRQ] && wr_status ##1 !status_q[ASRC_EV_IRQ]);

  // ----------------------------------------------------------------
  // Status, bus timing and register checks
  // ----------------------------------------------------------------
  // A sticky bit survives every cycle that neither sets nor clears it,
  // and a written one clears it unless a new event lands at once
  chk_seq_sets: assert property (
    @(posedge hclk) disable iff (!hresetn)
    seq_done |=> status_q[ASRC_EV_SEQ])
    else $error("sequence event lost");
  chk_status_sticky: assert property (
    @(posedge hclk) disable iff (!hresetn)
    status_q[ASRC_EV_IRQ] && !(wr_status && hwdata[ASRC_EV_IRQ])
      |=> status_q[ASRC_EV_IRQ])
    else $error("interrupt status not sticky");
  chk_w1c_clears: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_status && hwdata[ASRC_EV_IRQ] && !irq_point
      |=> !status_q[ASRC_EV_IRQ])
    else $error("written one did not clear status");
  // With every source masked the line stays low whatever is pending
  chk_irq_masked: assert property (
    @(posedge hclk) disable iff (!hresetn)
    mask_q == ASRC_EV_RST |-> !irq)
    else $error("masked status raised the interrupt");
  // Writes never stall, so back-to-back stores keep the full bus rate
  chk_write_fast: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_pend_q |-> hreadyout)
    else $error("write inserted a wait state");
  chk_ctrl2_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !wr_ctrl2 |=> $stable(ctrl2_q))
    else $error("control register changed without a write");
  chk_unmapped_zero: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rd_rdy_q && addr_q > ASRC_OFS_STATE |-> hrdata == 32'h0000_0000)
    else $error("unmapped address read nonzero");

endmodule

// ---- dv/asrc_fe_model.sv ----
// ------------------------------------------------------------
// Converter front end: sequencing events towards the block
// ------------------------------------------------------------
module asrc_fe_model
(
  // Clock
  input wire logic hclk,
  // Sequencing events, one-cycle pulses
  output logic seq_begin,
  output logic sample_done,
  output logic seq_done,
  // Input switch controls from the block
  input wire logic input_ground_tie,
  input wire logic input_switch_en
);
  timeunit 1ns;
  timeprecision 1ps;

  // Offset the converter adds to every result; the value is arbitrary
  localparam logic [9:0] OFFSET_CODE = 10'h017;

  // One conversion of an input level under the present switch state;
  // an open input with no ground tie gives a full-scale reading
  function automatic logic [9:0] convert(input logic [9:0] level);
    convert = input_ground_tie ? OFFSET_CODE
            : input_switch_en ? level + OFFSET_CODE : 10'h3FF;
  endfunction

  // Quiet until the bench asks for events
  initial
  begin
    seq_begin = 1'b0;
    sample_done = 1'b0;
    seq_done = 1'b0;
  end

  // Event order {begin, sample, done}; gap models a slow converter
  task automatic pulse(input logic [2:0] ev, input int gap);
    @(posedge hclk);
    {seq_begin, sample_done, seq_done} <= ev;
    @(posedge hclk);
    {seq_begin, sample_done, seq_done} <= 3'h0;
    repeat (gap) @(posedge hclk);
  endtask

  // A sequence completes only after its sample was taken
  task automatic run(input int nseq, input int gap);
    for (int i = 0; i < nseq; i++)
    begin
      pulse(3'h2, gap);
      pulse(3'h1, gap);
    end
  endtask
endmodule

// ---- dv/asrc_top_test.sv ----
module asrc_top_test
  import asrc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // Signals and bookkeeping
  // ------------------------------------------------------------
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic seq_begin, sample_done, seq_done;
  logic vref_pos_ext, vref_neg_ext, input_ground_tie, input_switch_en;
  logic scan_enable, select_alternate;
  logic rd_pend = 1'b0;
  logic [31:0] exp_q[$];
  int errors = 0;
  int samples_checked = 0;
  int seed = 32'h276FA6C1;
  int n;
  logic [9:0] ofs, cres;
  logic [6:0] e7;

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  asrc_top u_asrc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .seq_begin(seq_begin),
    .sample_done(sample_done), .seq_done(seq_done),
    .vref_pos_ext(vref_pos_ext), .vref_neg_ext(vref_neg_ext),
    .input_ground_tie(input_ground_tie),
    .input_switch_en(input_switch_en), .scan_enable(scan_enable),
    .select_alternate(select_alternate), .irq(irq));

  asrc_fe_model u_asrc_fe_model (.hclk(hclk), .seq_begin(seq_begin),
    .sample_done(sample_done), .seq_done(seq_done),
    .input_ground_tie(input_ground_tie),
    .input_switch_en(input_switch_en));

  // ------------------------------------------------------------
  // Compare and bus tasks
  // ------------------------------------------------------------
  task automatic fail(input string msg);
    errors++;
    $display("Error at %0t: %s", $time, msg);
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] e);
    samples_checked++;
    if (got !== e)
      fail($sformatf("read %h, expected %h", got, e));
  endtask

  // Output levels {pos, neg, tie, switch, scan, alt, irq}, masked
  task automatic outs(input logic [6:0] m, input logic [6:0] e);
    logic [6:0] got;
    @(posedge hclk);
    @(negedge hclk);
    got = {vref_pos_ext, vref_neg_ext, input_ground_tie, input_switch_en,
      scan_enable, select_alternate, irq};
    samples_checked++;
    if ((got & m) !== (e & m))
      fail($sformatf("outputs %b, expected %b", got & m, e & m));
  endtask

  // Address phase held until ready, then data phase held until ready
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask

  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Read monitor: values seen here are those from before the edge
  always @(posedge hclk)
  begin
    if (rd_pend && hreadyout === 1'b1)
    begin
      if (exp_q.size() == 0)
        fail("read data with no expectation");
      else
        // An error response spoils the word so that it cannot pass
        cmp_word(hresp ? 32'hFFFF_FFFF : hrdata, exp_q.pop_front());
    end
    if (hreadyout === 1'b1)
      rd_pend <= hsel && htrans[1] && !hwrite;
  end

  // Watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    #800000;
    fail("watchdog expired");
    stop_test();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    outs(7'h7F, 7'h08);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h0C, 32'h0);
    $display("reset test done");
    // Bit 1 kept at zero and count code 1111 avoided, as software must
    wr(8'h00, 32'hFFFFFFF9);
    rd(8'h00, 32'h0000F439);
    wr(8'h10, 32'hFFFFFFFF);
    rd(8'h10, 32'h0);
    // A second reset in mid-run clears the writable fields
    @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    rd(8'h00, 32'h0);
    $display("register test done");
    // Every reference code, with random scan and count fields
    for (int c = 0; c < 8; c++)
    begin
      r = $random(seed);
      if (r[4:1] == 4'hF)
        r[4:1] = 4'hE;
      wr(8'h00, {16'h0, c[2:0], 2'h0, r[0], 4'h0, r[4:1], 2'h0});
      e7 = {!c[2] && c[0], !c[2] && c[1], 2'h1, r[0], 2'h0};
      outs(7'h7C, e7);
    end
    $display("reference test done");
    // Calibration overrides the input switch and alternation, with scan and external references set
    wr(8'h00, 32'h00007401);
    outs(7'h1A, 7'h10);
    ofs = u_asrc_fe_model.convert(10'h155);
    u_asrc_fe_model.pulse(3'h4, 0);
    u_asrc_fe_model.pulse(3'h2, 0);
    outs(7'h1A, 7'h10);
    wr(8'h00, 32'h00006401);
    outs(7'h18, 7'h08);
    // Software adds the two's complement of the stored offset result
    cres = u_asrc_fe_model.convert(10'h155) + ~ofs + 10'h1;
    cmp_word({22'h0, cres}, 32'h155);
    $display("calibration test done");
    // Alternation starts on the primary selector at sequencing begin
    wr(8'h00, 32'h00000001);
    u_asrc_fe_model.pulse(3'h4, 0);
    outs(7'h02, 7'h00);
    for (int k = 1; k < 6; k++)
    begin
      u_asrc_fe_model.pulse(3'h2, $random(seed) & 32'h3);
      outs(7'h02, {5'h0, k[0], 1'b0});
      rd(8'h0C, {27'h0, k[0], 4'h0});
    end
    wr(8'h00, 32'h0);
    // The cleared bit reaches the selector output two edges later
    @(posedge hclk);
    outs(7'h02, 7'h00);
    u_asrc_fe_model.pulse(3'h2, 0);
    outs(7'h02, 7'h00);
    $display("alternation test done");
    // Interrupt after N+1 sequences, counter restarting each time
    for (int i = 0; i < 4; i++)
    begin
      n = (i == 0) ? 0 : (i == 1) ? 1 : (i == 2) ? 3 : 14;
      wr(8'h08, 32'h1);
      wr(8'h00, n << 2);
      wr(8'h04, 32'h3);
      u_asrc_fe_model.pulse(3'h4, 0);
      u_asrc_fe_model.run(n, $random(seed) & 32'h1);
      outs(7'h01, 7'h00);
      rd(8'h04, (n > 0) ? 32'h2 : 32'h0);
      rd(8'h0C, n);
      u_asrc_fe_model.run(1, 0);
      outs(7'h01, 7'h01);
      rd(8'h04, 32'h3);
      rd(8'h0C, 32'h0);
      wr(8'h04, 32'h1);
      outs(7'h01, 7'h00);
      rd(8'h04, 32'h2);
    end
    // Masked event stays sticky but quiet until unmasked
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h0);
    wr(8'h04, 32'h3);
    u_asrc_fe_model.run(1, 2);
    outs(7'h01, 7'h00);
    rd(8'h04, 32'h3);
    wr(8'h08, 32'h1);
    outs(7'h01, 7'h01);
    wr(8'h04, 32'h3);
    outs(7'h01, 7'h00);
    $display("interrupt test done");
    repeat (2) @(posedge hclk);
    if (exp_q.size() != 0)
      fail("reads left unanswered");
    stop_test();
  end
endmodule
